// File: inc/arpt_cfg.svh
// constants for the auto-reload pwm timer: register offsets, fields, resets, counts
// assumes a 32-bit avalon-mm slave, one register per aligned word
`ifndef ARPT_CFG_SVH
`define ARPT_CFG_SVH
// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define ARPT_IDX_CSR 5'h0d
`define ARPT_IDX_CNTH 5'h0e
`define ARPT_IDX_CNTL 5'h0f
`define ARPT_IDX_RLDH 5'h10
`define ARPT_IDX_RLDL 5'h11
`define ARPT_IDX_PINC 5'h12
`define ARPT_IDX_PCSR 5'h13
`define ARPT_IDX_DUTH 5'h17
`define ARPT_IDX_DUTL 5'h18
`define ARPT_IDX_MODE 5'h19
// ----------------------------------------
// fields
// ----------------------------------------
`define ARPT_CSR_CKSEL_LO 3
`define ARPT_CSR_OVF 2
`define ARPT_CSR_OVERFLOW_IRQ_ENABLE 1
`define ARPT_CSR_COMPARE_IRQ_ENABLE 0
`define ARPT_PCSR_POL 1
`define ARPT_PCSR_CMPF 0
`define ARPT_PINC_OE 0
`define ARPT_MODE_SLOW 0
`define ARPT_MODE_HALT 1
`define ARPT_MODE_AHALT 2
// ----------------------------------------
// resets and counts
// ----------------------------------------
`define ARPT_RST_BYTE 8'h00
`define ARPT_CNT_MAX 12'hfff
`define ARPT_SLOW_DIV 32
`endif

// File: inc/arpt_pkg.sv
// types for the auto-reload pwm timer
// assumes arpt_cfg.svh is on the include path
package arpt_pkg;
  typedef enum logic [1:0] {
    ARPT_CK_OFF = 2'h0,
    ARPT_CK_TICK = 2'h1,
    ARPT_CK_CPU = 2'h2,
    ARPT_CK_RSVD = 2'h3
  } arpt_cksel_t;

  typedef enum logic [1:0] {
    ARPT_BUS_IDLE = 2'h1,
    ARPT_BUS_ACK = 2'h2
  } arpt_bus_t;

  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } arpt_av_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } arpt_av_rsp_t;

  typedef struct packed {
    logic pwm_output;
    logic pwm_pin_enable;
    logic ovf_irq;
    logic cmp_irq;
    logic wake_active_halt;
  } arpt_out_t;

  typedef struct packed {
    arpt_bus_t bus;
    logic [31:0] rdata;
    arpt_cksel_t counter_clock_select;
    logic overflow_flag;
    logic [1:0] ovf_hold;
    logic overflow_irq_enable;
    logic compare_irq_enable;
    logic [11:0] counter_value;
    logic [11:0] reload_value;
    logic pwm_pin_control;
    logic output_polarity;
    logic compare_flag;
    logic [11:0] duty_value;
    logic [11:0] shadow_duty;
    logic cmp_locked;
    logic [4:0] slow_cnt;
    logic [2:0] power_mode;
    logic pwm_level;
    arpt_out_t out;
  } arpt_state_t;
endpackage

// File: core/arpt_timer.sv
// auto-reload 12-bit pwm timer with output compare, registers on avalon-mm
// assumes a synchronous 1 ms tick pulse input and power-mode bits set by software
//
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "arpt_cfg.svh"
// What this block does
// - pwm period is 4096 minus reload counter clocks.
// - counter starts from zero after reset.
// - overflow loads reload, moves duty to shadow, sets pwm high.
// - counter equal to active duty drives pwm low until next overflow.
// - polarity bit inverts pwm on the pin.
// - pin enable drives pin as push-pull pwm output.
// - high duty byte write suspends matching until low byte written.
// - with pin disabled, written duty compares at once.
// - match sets compare flag in both modes; irq if enabled.
// - compare works only with nonzero duty.
// - shadow copied each overflow; pwm uses shadow, compare uses duty.
// - slow divides counter clock by 32; halt stops.
// - active-halt stops unless tick clock and overflow irq enabled.
// - overflow and compare each drive own enabled irq.
// - clock select bits 4:3: off, tick, cpu, reserved; reset off.
// - overflow flag sets on wrap from fff; clears on status read.
// - overflow flag stays visible one more counter clock after clear.
// - control bit 1 enables overflow irq, bit 0 compare irq.
// - counter counts while clocked, read-only through two bytes.
// - compare flag clears on pwm status register read.
// - polarity clears at reset.
module arpt_timer (
  input wire logic clk, // 125 mhz clock
  input wire logic arst_n, // async reset, active low
  input wire logic timebase_tick, // 1 ms tick pulse, one cycle
  input wire arpt_pkg::arpt_av_req_t av_req, // avalon request
  output var arpt_pkg::arpt_av_rsp_t av_rsp, // avalon response
  output var arpt_pkg::arpt_out_t tmr_out // pin and irq outputs
);
  import arpt_pkg::*;

  arpt_state_t r, next_r;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [4:0] reg_idx(input logic [7:0] a);
    reg_idx = a[6:2];
  endfunction

  function automatic logic [7:0] hi_byte(input logic [11:0] v);
    hi_byte = {4'h0, v[11:8]};
  endfunction

  logic raw_en, cnt_en, ovf_ev, cmp_ev, rd_go, wr_go;
  logic [11:0] cmp_val;
  logic [4:0] idx;
  logic [7:0] wb;
  logic [7:0] rb;

  always_comb begin
    next_r = r;
    idx = reg_idx(av_req.address);
    wb = av_req.writedata[7:0];
    rd_go = (r.bus == ARPT_BUS_IDLE) && av_req.read;
    wr_go = (r.bus == ARPT_BUS_IDLE) && av_req.write;
    // counter clock source, slow division and power modes
    unique case (r.counter_clock_select)
      ARPT_CK_TICK: raw_en = timebase_tick;
      ARPT_CK_CPU: raw_en = 1'b1;
      default: raw_en = 1'b0;
    endcase
    if (r.power_mode[`ARPT_MODE_SLOW] && raw_en) begin
      next_r.slow_cnt = r.slow_cnt + 5'h1;
    end
    cnt_en = raw_en && (!r.power_mode[`ARPT_MODE_SLOW] ||
             r.slow_cnt == 5'(`ARPT_SLOW_DIV - 1));
    if (r.power_mode[`ARPT_MODE_HALT]) begin
      cnt_en = 1'b0;
    end
    if (r.power_mode[`ARPT_MODE_AHALT] &&
        !(r.counter_clock_select == ARPT_CK_TICK && r.overflow_irq_enable)) begin
      cnt_en = 1'b0;
    end
    ovf_ev = cnt_en && r.counter_value == `ARPT_CNT_MAX;
    // pwm mode uses the shadow, compare mode the live duty
    cmp_val = r.pwm_pin_control ? r.shadow_duty : r.duty_value;
    cmp_ev = cnt_en && !ovf_ev && !r.cmp_locked && cmp_val != 12'h000 &&
             (r.counter_value + 12'h001) == cmp_val;
    if (ovf_ev) begin
      next_r.counter_value = r.reload_value;
      next_r.shadow_duty = r.duty_value;
      next_r.pwm_level = 1'b1;
      next_r.ovf_hold = 2'h0;
    end else if (cnt_en) begin
      next_r.counter_value = r.counter_value + 12'h001;
      if (cmp_ev) begin
        next_r.pwm_level = 1'b0;
      end
      if (r.ovf_hold == 2'h1) begin
        next_r.ovf_hold = 2'h2;
      end
    end
    // ----------------------------------------
    // register bus
    // ----------------------------------------
    rb = 8'h00;
    unique case (idx)
      5'(`ARPT_IDX_CSR): rb = {3'h0, r.counter_clock_select, r.overflow_flag,
                              r.overflow_irq_enable, r.compare_irq_enable};
      5'(`ARPT_IDX_CNTH): rb = hi_byte(r.counter_value);
      5'(`ARPT_IDX_CNTL): rb = r.counter_value[7:0];
      `ARPT_IDX_RLDH: rb = hi_byte(r.reload_value);
      `ARPT_IDX_RLDL: rb = r.reload_value[7:0];
      `ARPT_IDX_PINC: rb = {7'h0, r.pwm_pin_control};
      `ARPT_IDX_PCSR: rb = {6'h0, r.output_polarity, r.compare_flag};
      `ARPT_IDX_DUTH: rb = hi_byte(r.duty_value);
      `ARPT_IDX_DUTL: rb = r.duty_value[7:0];
      `ARPT_IDX_MODE: rb = {5'h0, r.power_mode};
      default: rb = 8'h00;
    endcase
    unique case (r.bus)
      ARPT_BUS_IDLE: begin
        if (rd_go || wr_go) begin
          next_r.bus = ARPT_BUS_ACK;
          next_r.rdata = rd_go ? {24'h0, rb} : 32'h0;
        end
      end
      ARPT_BUS_ACK: next_r.bus = ARPT_BUS_IDLE;
    endcase
    if (wr_go) begin
      unique case (idx)
        5'(`ARPT_IDX_CSR): begin
          next_r.counter_clock_select = arpt_cksel_t'(wb[`ARPT_CSR_CKSEL_LO +: 2]);
          next_r.overflow_irq_enable = wb[`ARPT_CSR_OVERFLOW_IRQ_ENABLE];
          next_r.compare_irq_enable = wb[`ARPT_CSR_COMPARE_IRQ_ENABLE];
        end
        `ARPT_IDX_RLDH: next_r.reload_value[11:8] = wb[3:0];
        `ARPT_IDX_RLDL: next_r.reload_value[7:0] = wb;
        `ARPT_IDX_PINC: next_r.pwm_pin_control = wb[`ARPT_PINC_OE];
        `ARPT_IDX_PCSR: next_r.output_polarity = wb[`ARPT_PCSR_POL];
        `ARPT_IDX_DUTH: begin
          next_r.duty_value[11:8] = wb[3:0];
          next_r.cmp_locked = 1'b1;
        end
        `ARPT_IDX_DUTL: begin
          next_r.duty_value[7:0] = wb;
          next_r.cmp_locked = 1'b0;
        end
        `ARPT_IDX_MODE: next_r.power_mode = wb[2:0];
        default: ;
      endcase
    end
    // flags: a read clears, a same-cycle event wins
    if (rd_go && idx == 5'(`ARPT_IDX_CSR) && r.overflow_flag) begin
      next_r.ovf_hold = 2'h1;
    end
    if (r.ovf_hold == 2'h2 || (r.ovf_hold == 2'h1 && !r.overflow_flag)) begin
      next_r.overflow_flag = 1'b0;
      next_r.ovf_hold = 2'h0;
    end
    if (ovf_ev) begin
      next_r.overflow_flag = 1'b1;
      next_r.ovf_hold = 2'h0;
    end
    if (rd_go && idx == `ARPT_IDX_PCSR) begin
      next_r.compare_flag = 1'b0;
    end
    if (cmp_ev) begin
      next_r.compare_flag = 1'b1;
    end
    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    next_r.out.pwm_pin_enable = next_r.pwm_pin_control;
    next_r.out.pwm_output = next_r.pwm_pin_control &&
                            (next_r.pwm_level ^ next_r.output_polarity);
    next_r.out.ovf_irq = next_r.overflow_flag && next_r.overflow_irq_enable;
    next_r.out.cmp_irq = next_r.compare_flag && next_r.compare_irq_enable;
    next_r.out.wake_active_halt = next_r.out.ovf_irq &&
                                  next_r.counter_clock_select == ARPT_CK_TICK;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
      r.bus <= ARPT_BUS_IDLE;
      r.counter_clock_select <= ARPT_CK_OFF;
    end else begin
      r <= next_r;
    end
  end

  assign av_rsp.readdata = r.rdata;
  assign av_rsp.waitrequest = (r.bus == ARPT_BUS_IDLE);
  assign tmr_out = r.out;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_wrap;
    cnt_en && r.counter_value == `ARPT_CNT_MAX;
  endsequence

  property p_reload;
    @(posedge clk) disable iff (!arst_n)
      s_wrap |=> r.counter_value == $past(r.reload_value);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload on wrap");

  property p_pwm_high;
    @(posedge clk) disable iff (!arst_n) s_wrap |=> r.pwm_level;
  endproperty
  a_pwm_high: assert property (p_pwm_high) else $error("pwm not high on wrap");

  property p_ovf_set;
    @(posedge clk) disable iff (!arst_n) s_wrap |=> r.overflow_flag;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

  property p_cmp_low;
    @(posedge clk) disable iff (!arst_n) cmp_ev |=> !r.pwm_level && r.compare_flag;
  endproperty
  a_cmp_low: assert property (p_cmp_low) else $error("match did not act");

  property p_lock;
    @(posedge clk) disable iff (!arst_n) r.cmp_locked |-> !cmp_ev;
  endproperty
  a_lock: assert property (p_lock) else $error("match while locked");

  property p_zero_duty;
    @(posedge clk) disable iff (!arst_n) (cmp_val == 12'h000) |-> !cmp_ev;
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("match at zero duty");

  property p_off_hold;
    @(posedge clk) disable iff (!arst_n)
      (r.counter_clock_select inside {ARPT_CK_OFF, ARPT_CK_RSVD}) |=>
        $stable(r.counter_value) || $past(ovf_ev);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("counter ran while off");

  property p_halt;
    @(posedge clk) disable iff (!arst_n) r.power_mode[`ARPT_MODE_HALT] |-> !cnt_en;
  endproperty
  a_halt: assert property (p_halt) else $error("counter ran in halt");

  property p_irq;
    @(posedge clk) disable iff (!arst_n)
      tmr_out.cmp_irq |-> r.compare_irq_enable && r.compare_flag;
  endproperty
  a_irq: assert property (p_irq) else $error("compare irq unmasked");
endmodule
`default_nettype wire

// File: dv/arpt_load.sv
// load on the pwm pin: measures the last high pulse and the last period
// assumes the bench resolves the pin level, pulled low when released
`timescale 1ns/1ps
`default_nettype none
module arpt_load (
  input wire logic clk, // clock
  input wire logic arst_n, // async reset, active low
  input wire logic pin, // resolved pin level
  output logic [15:0] hi_len, // last high pulse, cycles
  output logic [15:0] per_len // last rise to rise, cycles
);
  logic prev;
  logic [15:0] hc;
  logic [15:0] pc;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev <= 1'b0;
      hc <= 16'h0000;
      pc <= 16'h0000;
      hi_len <= 16'h0000;
      per_len <= 16'h0000;
    end else begin
      prev <= pin;
      pc <= (pin && !prev) ? 16'h0001 : pc + 16'h0001;
      hc <= (pin && !prev) ? 16'h0001 : hc + {15'h0000, pin};
      if (pin && !prev) begin
        per_len <= pc;
      end
      if (!pin && prev) begin
        hi_len <= hc;
      end
    end
  end
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// bench for the auto-reload pwm timer: register sequences with expected values
// assumes arpt_pkg compiled first and arpt_cfg.svh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "arpt_cfg.svh"
module tb_top;
  import arpt_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic tick = 1'b0;
  arpt_av_req_t req = '0;
  arpt_av_rsp_t rsp;
  arpt_out_t out;
  wire logic pin;
  logic [15:0] hi_len;
  logic [15:0] per_len;
  int bad_count = 0;
  int checks = 0;
  logic [11:0] c0;
  logic [11:0] c1;
  logic [7:0] q0;
  logic [4:0] regs [10] = '{5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13,
    5'h17, 5'h18, 5'h19};
  always #4 clk = ~clk;
  // released pin is pulled low by the load
  assign pin = out.pwm_pin_enable ? out.pwm_output : 1'b0;
  arpt_timer u_dut (.clk(clk), .arst_n(arst_n), .timebase_tick(tick),
    .av_req(req), .av_rsp(rsp), .tmr_out(out));
  arpt_load u_load (.clk(clk), .arst_n(arst_n), .pin(pin), .hi_len(hi_len),
    .per_len(per_len));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 5000) begin
      bad_count++;
      $display("[ERR] %0t wait timed out", $time);
      wrap_up();
    end
  endtask
  // one transfer, entered just after a rising edge; held until waitrequest is
  // sampled low at a rising edge, released there, then one idle cycle
  task automatic xfer(input logic [4:0] i, input logic w, input logic [7:0] d,
    output logic [7:0] q);
    int n;
    n = 0;
    req <= '{address: {1'b0, i, 2'b00}, read: !w, write: w, writedata: {24'h0, d}};
    do begin
      @(posedge clk);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 5000);
    tmo(n);
    q = rsp.readdata[7:0];
    req <= '0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [4:0] i, input logic [7:0] d);
    logic [7:0] q;
    xfer(i, 1'b1, d, q);
  endtask
  task automatic rc(input logic [4:0] i, input logic [7:0] e);
    logic [7:0] q;
    xfer(i, 1'b0, 8'h00, q);
    chk({8'h00, q}, {8'h00, e});
  endtask
  task automatic rdcnt(output logic [11:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    xfer(`ARPT_IDX_CNTL, 1'b0, 8'h00, lo);
    xfer(`ARPT_IDX_CNTH, 1'b0, 8'h00, hi);
    v = {hi[3:0], lo};
  endtask
  task automatic ticks(input int k);
    repeat (k) begin
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  // waits for the overflow irq (1) or the compare irq (0)
  task automatic wait_irq(input logic ovf);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((ovf ? out.ovf_irq : out.cmp_irq) !== 1'b1 && n < 5000);
    tmo(n);
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    foreach (regs[k]) rc(regs[k], 8'h00);
    rc(5'h1f, 8'h00);
    wr(`ARPT_IDX_RLDH, 8'hff);
    rc(`ARPT_IDX_RLDH, 8'h0f);
    wr(`ARPT_IDX_CNTL, 8'h55);
    wr(`ARPT_IDX_CSR, 8'h18);
    repeat (20) @(posedge clk);
    rc(`ARPT_IDX_CNTL, 8'h00);
    wr(`ARPT_IDX_DUTH, 8'h0f);
    wr(`ARPT_IDX_DUTL, 8'h40);
    wr(`ARPT_IDX_PINC, 8'h01);
    wr(`ARPT_IDX_CSR, 8'h10);
    // counter starts at zero, so the first wrap is a full 4096 counts away
    repeat (4700) @(posedge clk);
    chk(per_len, 16'h0100);
    chk(hi_len, 16'h0040);
    chk({15'h0000, out.pwm_pin_enable}, 16'h0001);
    wr(`ARPT_IDX_PCSR, 8'h02);
    repeat (600) @(posedge clk);
    chk(hi_len, 16'h00c0);
    wr(`ARPT_IDX_PCSR, 8'h00);
    wr(`ARPT_IDX_DUTH, 8'h0f);
    repeat (600) @(posedge clk);
    chk({15'h0000, out.pwm_output}, 16'h0001);
    wr(`ARPT_IDX_DUTL, 8'h80);
    repeat (600) @(posedge clk);
    chk(hi_len, 16'h0080);
    wr(`ARPT_IDX_CSR, 8'h12);
    wait_irq(1'b1);
    rc(`ARPT_IDX_CSR, 8'h16);
    rc(`ARPT_IDX_CSR, 8'h12);
    chk({15'h0000, out.ovf_irq}, 16'h0000);
    wr(`ARPT_IDX_MODE, 8'h02);
    rdcnt(c0);
    rdcnt(c1);
    chk({4'h0, c1}, {4'h0, c0});
    wr(`ARPT_IDX_MODE, 8'h01);
    repeat (17000) @(posedge clk);
    chk(per_len, 16'h2000);
    wr(`ARPT_IDX_MODE, 8'h00);
    wr(`ARPT_IDX_PINC, 8'h00);
    chk({14'h0000, out.pwm_pin_enable, out.pwm_output}, 16'h0000);
    wr(`ARPT_IDX_CSR, 8'h11);
    wr(`ARPT_IDX_DUTH, 8'h0f);
    wr(`ARPT_IDX_DUTL, 8'h90);
    xfer(`ARPT_IDX_PCSR, 1'b0, 8'h00, q0);
    wait_irq(1'b0);
    rc(`ARPT_IDX_PCSR, 8'h01);
    rc(`ARPT_IDX_PCSR, 8'h00);
    wr(`ARPT_IDX_RLDH, 8'h00);
    wr(`ARPT_IDX_DUTH, 8'h00);
    wr(`ARPT_IDX_DUTL, 8'h00);
    xfer(`ARPT_IDX_PCSR, 1'b0, 8'h00, q0);
    repeat (4200) @(posedge clk);
    rc(`ARPT_IDX_PCSR, 8'h00);
    wr(`ARPT_IDX_CSR, 8'h08);
    wr(`ARPT_IDX_MODE, 8'h04);
    rdcnt(c0);
    ticks(3);
    rdcnt(c1);
    chk({4'h0, c1}, {4'h0, c0});
    wr(`ARPT_IDX_CSR, 8'h0a);
    rdcnt(c0);
    ticks(3);
    rdcnt(c1);
    chk({4'h0, c1}, {4'h0, c0 + 12'h003});
    wrap_up();
  end
endmodule
`default_nettype wire
